// ---- src/phy_ctl_pkg.sv ----
// Constants, types and layout for the phy control request handler
package phy_ctl_pkg;
    // Phy count and index width
    localparam int NPHY = 8;
    localparam int PHYW = 3;
    // Frame header codes
    localparam logic [7:0] FRAME_REQ = 8'h40;
    localparam logic [7:0] FRAME_RSP = 8'h41;
    localparam logic [7:0] FUNC_PHY_CTL = 8'h91;
    localparam logic [7:0] LEN_NEW = 8'h09;
    localparam logic [7:0] LEN_OLD = 8'h00;
    localparam logic [7:0] RSP_LEN = 8'h00;
    // Bytes before the checksum
    localparam logic [5:0] REQ_BYTES = 6'h28;
    // Byte positions inside the request
    localparam logic [5:0] B_TYPE = 6'h00;
    localparam logic [5:0] B_FUNC = 6'h01;
    localparam logic [5:0] B_LEN = 6'h03;
    localparam logic [5:0] B_PHY = 6'h09;
    localparam logic [5:0] B_OP = 6'h0A;
    localparam logic [5:0] B_UPD = 6'h0B;
    localparam logic [5:0] B_MINR = 6'h20;
    localparam logic [5:0] B_MAXR = 6'h21;
    localparam logic [5:0] B_PPTV = 6'h24;
    // Phy operation codes
    localparam logic [7:0] OP_NOP = 8'h00;
    localparam logic [7:0] OP_LINK_RST = 8'h01;
    localparam logic [7:0] OP_HARD_RST = 8'h02;
    localparam logic [7:0] OP_DISABLE = 8'h03;
    localparam logic [7:0] OP_CLR_ERR = 8'h05;
    localparam logic [7:0] OP_CLR_AFF = 8'h06;
    // Function result codes
    localparam logic [7:0] RES_ACCEPTED = 8'h00;
    localparam logic [7:0] RES_UNKNOWN = 8'h01;
    localparam logic [7:0] RES_FAILED = 8'h02;
    // Link rate codes
    localparam logic [3:0] RATE_KEEP = 4'h0;
    localparam logic [3:0] RATE_1G5 = 4'h8;
    localparam logic [3:0] RATE_3G0 = 4'h9;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_VIRT = 8'h04;
    localparam logic [7:0] OFS_STAT = 8'h08;
    localparam logic [7:0] OFS_CNT = 8'h0C;
    localparam logic [7:0] OFS_DIS = 8'h10;
    // Reset values
    localparam logic CTRL_RST = 1'b1;
    localparam logic [NPHY-1:0] VIRT_RST = 8'h00;
    // Handler states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01,
        ST_RESP = 2'b10
    } st_t;
    // Captured request fields
    typedef struct packed {
        logic [7:0] ftype;
        logic [7:0] func;
        logic [7:0] len;
        logic [7:0] phy;
        logic [7:0] op;
        logic upd;
        logic [3:0] minr;
        logic [3:0] maxr;
        logic [3:0] pptv;
    } req_t;
endpackage : phy_ctl_pkg

// ---- src/phy_control_request_handler.sv ----
// Phy control request handler with AHB-Lite control registers
`timescale 1ns/1ps
`default_nettype none
module phy_control_request_handler (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Request byte stream, checksum already stripped
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_last,
    output logic rx_ready,
    // Response byte stream, checksum appended downstream
    output logic tx_valid,
    output logic [7:0] tx_data,
    output logic tx_last,
    input wire logic tx_ready,
    // Connection context
    input wire logic [7:0] conn_phy,
    input wire logic [63:0] conn_addr,
    input wire logic [phy_ctl_pkg::NPHY-1:0] attached_sata,
    // Affiliation store lookup
    output logic [7:0] aff_phy,
    output logic [63:0] aff_addr,
    input wire logic aff_match,
    // Per-phy control, one bit per phy
    output logic [phy_ctl_pkg::NPHY-1:0] lrst_req,
    output logic [phy_ctl_pkg::NPHY-1:0] hrst_req,
    output logic [phy_ctl_pkg::NPHY-1:0] skip_spinup,
    output logic [phy_ctl_pkg::NPHY-1:0] vrst_req,
    output logic [phy_ctl_pkg::NPHY-1:0] phy_disabled,
    output logic [phy_ctl_pkg::NPHY-1:0] errlog_clr,
    output logic [phy_ctl_pkg::NPHY-1:0] aff_clear,
    output logic [phy_ctl_pkg::NPHY-1:0] aff_release,
    // Per-phy programmed values, four bits per phy
    output logic [phy_ctl_pkg::NPHY*4-1:0] min_rate,
    output logic [phy_ctl_pkg::NPHY*4-1:0] max_rate,
    output logic [phy_ctl_pkg::NPHY*4-1:0] pptv
);
    import phy_ctl_pkg::*;

    // Rate code check, used for both limits
    function automatic logic rate_valid(input logic [3:0] r);
        rate_valid = (r == RATE_KEEP) || (r == RATE_1G5) || (r == RATE_3G0);
    endfunction : rate_valid

    // Handler state and captured frame
    st_t state_ff;
    req_t req_ff;
    logic [5:0] cnt_ff; // Bytes received
    logic [7:0] res_ff; // Result of last request
    logic [1:0] idx_ff; // Response byte index
    // Register file
    logic ctrl_ff; // Function enable
    logic [NPHY-1:0] virt_ff; // Virtual phy mask
    logic [31:0] reqcnt_ff; // Handled request count
    logic [7:0] last_op_ff;
    logic [7:0] last_phy_ff;
    // Bus data phase tracking
    logic wr_pend_ff;
    logic [7:0] wr_addr_ff;
    // Output flops
    logic [NPHY-1:0] lrst_ff, hrst_ff, skip_ff, vrst_ff;
    logic [NPHY-1:0] dis_ff, errclr_ff, affclr_ff, affrel_ff;
    logic [NPHY*4-1:0] minr_ff, maxr_ff, pptv_ff;
    logic [63:0] aff_addr_ff;
    logic tx_valid_ff, tx_last_ff;
    logic [7:0] tx_data_ff;
    logic [31:0] hrdata_ff;
    logic hreadyout_ff;

    // Decision terms for the execute cycle
    logic [NPHY-1:0] sel;
    logic phy_ok, rate_ok, own_phy, len_ok;
    logic [7:0] nxt_res;
    logic act;
    logic ahb_go;

    assign ahb_go = hsel & hready & htrans[1];

    // Decide the function result from the captured frame
    always_comb begin
        sel = '0;
        // Target phy from byte 9
        // select named phy
        if (req_ff.phy < 8'(NPHY)) begin
            sel[req_ff.phy[PHYW-1:0]] = 1'b1;
        end
        phy_ok = req_ff.phy < 8'(NPHY);
        own_phy = req_ff.phy == conn_phy;
        len_ok = ((req_ff.len == LEN_NEW) || (req_ff.len == LEN_OLD)) && (cnt_ff >= REQ_BYTES);
        rate_ok = rate_valid(req_ff.minr) && rate_valid(req_ff.maxr);
        if ((req_ff.minr != RATE_KEEP) && (req_ff.maxr != RATE_KEEP) && (req_ff.minr > req_ff.maxr)) begin
            rate_ok = 1'b0;
        end
        nxt_res = RES_ACCEPTED;
        if ((req_ff.func != FUNC_PHY_CTL) || !ctrl_ff) begin
            nxt_res = RES_UNKNOWN;
        end else if (!len_ok || !phy_ok || !rate_ok) begin
            nxt_res = RES_FAILED;
        end else begin
            case (req_ff.op)
                OP_NOP: nxt_res = RES_ACCEPTED;
                OP_LINK_RST, OP_HARD_RST, OP_DISABLE: begin
                    nxt_res = own_phy ? RES_FAILED : RES_ACCEPTED;
                end
                OP_CLR_ERR: nxt_res = RES_ACCEPTED;
                OP_CLR_AFF: begin
                    nxt_res = aff_match ? RES_ACCEPTED : RES_FAILED;
                end
                default: nxt_res = RES_FAILED;
            endcase
        end
        act = (state_ff == ST_EXEC) && (req_ff.ftype == FRAME_REQ) && (nxt_res == RES_ACCEPTED);
    end

    // Frame intake, execute and response sequencing
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_ff <= ST_IDLE;
            cnt_ff <= '0;
            req_ff <= '0;
            res_ff <= RES_ACCEPTED;
            idx_ff <= '0;
            aff_addr_ff <= '0;
        end else begin
            case (state_ff)
                // Collect bytes of interest
                ST_IDLE: begin
                    if (rx_valid) begin
                        if (cnt_ff != 6'h3F) begin
                            cnt_ff <= cnt_ff + 6'd1;
                        end
                        if (cnt_ff == B_TYPE) req_ff.ftype <= rx_data;
                        if (cnt_ff == B_FUNC) req_ff.func <= rx_data;
                        if (cnt_ff == B_LEN) req_ff.len <= rx_data;
                        if (cnt_ff == B_PHY) req_ff.phy <= rx_data;
                        if (cnt_ff == B_OP) req_ff.op <= rx_data;
                        if (cnt_ff == B_UPD) req_ff.upd <= rx_data[7];
                        if (cnt_ff == B_MINR) req_ff.minr <= rx_data[7:4];
                        if (cnt_ff == B_MAXR) req_ff.maxr <= rx_data[7:4];
                        if (cnt_ff == B_PPTV) req_ff.pptv <= rx_data[3:0];
                        if (rx_last) begin
                            // Lookup key
                            aff_addr_ff <= conn_addr;
                            state_ff <= ST_EXEC;
                        end
                    end
                end
                // One cycle to decide and act
                ST_EXEC: begin
                    cnt_ff <= '0;
                    res_ff <= nxt_res;
                    idx_ff <= '0;
                    if (req_ff.ftype == FRAME_REQ) begin
                        state_ff <= ST_RESP;
                    end else begin
                        state_ff <= ST_IDLE;
                    end
                end
                // Send the four response bytes
                ST_RESP: begin
                    if (tx_valid_ff && tx_ready) begin
                        idx_ff <= idx_ff + 2'd1;
                        if (idx_ff == 2'd3) begin
                            state_ff <= ST_IDLE;
                        end
                    end
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    // Response stream output flops
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_valid_ff <= 1'b0;
            tx_data_ff <= '0;
            tx_last_ff <= 1'b0;
        end else if (state_ff == ST_EXEC && req_ff.ftype == FRAME_REQ) begin
            tx_valid_ff <= 1'b1;
            tx_data_ff <= FRAME_RSP;
            tx_last_ff <= 1'b0;
        end else if (state_ff == ST_RESP && tx_valid_ff && tx_ready) begin
            // Advance or finish
            tx_valid_ff <= idx_ff != 2'd3;
            tx_last_ff <= idx_ff == 2'd2;
            case (idx_ff)
                2'd0: tx_data_ff <= FUNC_PHY_CTL;
                2'd1: tx_data_ff <= res_ff;
                2'd2: tx_data_ff <= RSP_LEN;
                default: tx_data_ff <= '0;
            endcase
        end
    end

    // One-cycle reset and clear pulses
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lrst_ff <= '0;
            hrst_ff <= '0;
            skip_ff <= '0;
            vrst_ff <= '0;
            errclr_ff <= '0;
            affclr_ff <= '0;
            affrel_ff <= '0;
        end else begin
            lrst_ff <= '0;
            hrst_ff <= '0;
            skip_ff <= '0;
            vrst_ff <= '0;
            errclr_ff <= '0;
            affclr_ff <= '0;
            affrel_ff <= '0;
            if (act) begin
                case (req_ff.op)
                    OP_LINK_RST: begin
                        lrst_ff <= sel & ~virt_ff;
                        vrst_ff <= sel & virt_ff;
                        skip_ff <= sel & ~virt_ff;
                    end
                    OP_HARD_RST: begin
                        lrst_ff <= sel & ~virt_ff;
                        hrst_ff <= sel & ~virt_ff & ~attached_sata;
                        skip_ff <= sel & ~virt_ff & attached_sata;
                        vrst_ff <= sel & virt_ff;
                        affclr_ff <= sel;
                    end
                    OP_CLR_ERR: errclr_ff <= sel;
                    OP_CLR_AFF: affrel_ff <= sel;
                    default: ;
                endcase
            end
        end
    end

    // Phy disable levels
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dis_ff <= '0;
        end else if (act) begin
            if (req_ff.op == OP_DISABLE) begin
                dis_ff <= dis_ff | sel;
            end else if (req_ff.op == OP_LINK_RST || req_ff.op == OP_HARD_RST) begin
                dis_ff <= dis_ff & ~sel;
            end
        end
    end

    // Programmed rates and pathway timeout per phy
    genvar g;
    generate
        for (g = 0; g < NPHY; g++) begin : g_phy
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    minr_ff[g*4 +: 4] <= RATE_KEEP;
                    maxr_ff[g*4 +: 4] <= RATE_KEEP;
                    pptv_ff[g*4 +: 4] <= '0;
                end else if (act && sel[g]) begin
                    if (req_ff.minr != RATE_KEEP) minr_ff[g*4 +: 4] <= req_ff.minr;
                    if (req_ff.maxr != RATE_KEEP) maxr_ff[g*4 +: 4] <= req_ff.maxr;
                    if (req_ff.upd) pptv_ff[g*4 +: 4] <= req_ff.pptv;
                end
            end
        end
    endgenerate

    // Status bookkeeping
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            reqcnt_ff <= '0;
            last_op_ff <= '0;
            last_phy_ff <= '0;
        end else if (state_ff == ST_EXEC && req_ff.ftype == FRAME_REQ) begin
            reqcnt_ff <= reqcnt_ff + 32'd1;
            last_op_ff <= req_ff.op;
            last_phy_ff <= req_ff.phy;
        end
    end

    // Bus address phase capture and read data
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= '0;
            hrdata_ff <= '0;
            hreadyout_ff <= 1'b1;
        end else begin
            hreadyout_ff <= 1'b1;
            wr_pend_ff <= ahb_go & hwrite;
            if (ahb_go) begin
                wr_addr_ff <= haddr[7:0];
            end
            if (ahb_go && !hwrite) begin
                // Unmapped reads return zero
                if (haddr[7:0] == OFS_CTRL) begin
                    hrdata_ff <= {31'd0, ctrl_ff};
                end else if (haddr[7:0] == OFS_VIRT) begin
                    hrdata_ff <= {24'd0, virt_ff};
                end else if (haddr[7:0] == OFS_STAT) begin
                    hrdata_ff <= {7'd0, state_ff != ST_IDLE, last_phy_ff, last_op_ff, res_ff};
                end else if (haddr[7:0] == OFS_CNT) begin
                    hrdata_ff <= reqcnt_ff;
                end else if (haddr[7:0] == OFS_DIS) begin
                    hrdata_ff <= {24'd0, dis_ff};
                end else begin
                    hrdata_ff <= '0;
                end
            end
        end
    end

    // Bus writes in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_ff <= CTRL_RST;
            virt_ff <= VIRT_RST;
        end else if (wr_pend_ff) begin
            if (wr_addr_ff == OFS_CTRL) begin
                ctrl_ff <= hwdata[0];
            end else if (wr_addr_ff == OFS_VIRT) begin
                virt_ff <= hwdata[NPHY-1:0];
            end
        end
    end

    // Port drive from flops, hresp tied low
    assign hreadyout = hreadyout_ff;
    assign hresp = 1'b0;
    assign hrdata = hrdata_ff;
    assign rx_ready = state_ff == ST_IDLE;
    assign tx_valid = tx_valid_ff;
    assign tx_data = tx_data_ff;
    assign tx_last = tx_last_ff;
    assign aff_phy = req_ff.phy;
    assign aff_addr = aff_addr_ff;
    assign lrst_req = lrst_ff;
    assign hrst_req = hrst_ff;
    assign skip_spinup = skip_ff;
    assign vrst_req = vrst_ff;
    assign phy_disabled = dis_ff;
    assign errlog_clr = errclr_ff;
    assign aff_clear = affclr_ff;
    assign aff_release = affrel_ff;
    assign min_rate = minr_ff;
    assign max_rate = maxr_ff;
    assign pptv = pptv_ff;

    // Unused bus qualifiers
    logic unused_ok;
    assign unused_ok = &{1'b0, hsize, haddr[31:8]};
endmodule : phy_control_request_handler
`default_nettype wire

// ---- sim/phy_control_request_handler_checker.sv ----
// Port assertions for the phy control request handler
`timescale 1ns/1ps
`default_nettype none
module phy_control_request_handler_checker (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Streams
    input wire logic rx_ready,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_last,
    input wire logic tx_ready,
    // Per-phy control
    input wire logic [7:0] attached_sata,
    input wire logic [7:0] lrst_req,
    input wire logic [7:0] hrst_req,
    input wire logic [7:0] skip_spinup,
    input wire logic [7:0] vrst_req,
    input wire logic [7:0] phy_disabled
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // First response byte taken
    sequence s_first;
        tx_valid && tx_ready && tx_data == 8'h41;
    endsequence
    // Last response byte taken
    sequence s_end;
        tx_valid && tx_ready && tx_last;
    endsequence
    a_resp_type: assert property ($rose(tx_valid) |-> tx_data == 8'h41)
        else $error("Bad type byte");
    a_resp_func: assert property (s_first |=> tx_valid && tx_data == 8'h91)
        else $error("Bad function byte");
    a_resp_close: assert property (s_end |-> tx_data == 8'h00 ##1 !tx_valid && rx_ready)
        else $error("Bad response end");
    a_link_prompt: assert property ((|lrst_req) |-> tx_valid && tx_data == 8'h41)
        else $error("Link reset answer late");
    a_hard_prompt: assert property ((|hrst_req) |-> $rose(tx_valid))
        else $error("Hard reset answer late");
    a_hard_scope: assert property ((|hrst_req) |-> (hrst_req & ~(lrst_req & ~attached_sata)) == 8'h00)
        else $error("Stray hard reset");
    a_spinup_skip: assert property ((|lrst_req) |-> skip_spinup == (lrst_req & ~hrst_req))
        else $error("Bad spin-up bypass");
    a_virt_alone: assert property ((|vrst_req) |-> (lrst_req | hrst_req) == 8'h00)
        else $error("Virtual phy link reset");
    a_reset_enable: assert property ((|lrst_req) |=> (phy_disabled & $past(lrst_req)) == 8'h00)
        else $error("Reset phy disabled");
    a_disable_set: assert property ((|(phy_disabled & ~$past(phy_disabled))) |-> $rose(tx_valid))
        else $error("Stray disable");
endmodule : phy_control_request_handler_checker
bind phy_control_request_handler phy_control_request_handler_checker u_phy_control_request_handler_checker (
    .hclk, .hresetn, .rx_ready, .tx_valid, .tx_data, .tx_last, .tx_ready, .attached_sata,
    .lrst_req, .hrst_req, .skip_spinup, .vrst_req, .phy_disabled);
`default_nettype wire

// ---- sim/mgmt_initiator_model.sv ----
// Management initiator model: sends request frames, collects responses
`timescale 1ns/1ps
`default_nettype none
module mgmt_initiator_model (
    // Clock, reset and commands
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic start,
    input wire logic stall,
    input wire logic [319:0] frame,
    // Request stream
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_last,
    input wire logic rx_ready,
    // Response stream
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_last,
    output logic tx_ready,
    // Collected response
    output logic [31:0] rsp,
    output logic done
);
    logic [5:0] idx_ff; // Byte on offer
    logic busy_ff; // Awaiting the response
    // Response taken only while awaited, with stalls
    assign tx_ready = busy_ff & ~stall;
    // Offers bytes in order, gathers the reply
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_valid <= 1'b0;
            rx_data <= 8'hA5;
            rx_last <= 1'b0;
            idx_ff <= 6'h00;
            busy_ff <= 1'b0;
            rsp <= 32'h0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            // Idle data keeps moving
            if (!rx_valid) begin
                rx_data <= ~rx_data;
            end
            if (start) begin
                rx_valid <= 1'b1;
                rx_data <= frame[7:0];
                idx_ff <= 6'h00;
                busy_ff <= 1'b1;
            end else if (rx_valid && rx_ready) begin
                idx_ff <= idx_ff + 6'h01;
                rx_data <= rx_last ? ~rx_data : frame[8 * (idx_ff + 6'h01) +: 8];
                rx_valid <= !rx_last;
                rx_last <= idx_ff == 6'h26;
            end
            if (busy_ff && tx_valid && tx_ready) begin
                rsp <= {tx_data, rsp[31:8]};
                busy_ff <= !tx_last;
                done <= tx_last;
            end
        end
    end
endmodule : mgmt_initiator_model
`default_nettype wire

// ---- sim/phy_control_request_handler_tb.sv ----
// Self-checking bench for the phy control request handler
`timescale 1ns/1ps
`default_nettype none
module phy_control_request_handler_tb;
    import phy_ctl_pkg::*;
    // Bus side
    logic hclk = 1'b0;
    logic hresetn = 1'b1;
    logic hsel = 1'b0, hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic hreadyout, hresp;
    wire hready = hreadyout;
    // Streams and context
    logic rx_valid, rx_last, rx_ready, tx_valid, tx_last, tx_ready, done;
    logic [7:0] rx_data, tx_data, aff_phy, conn_phy = 8'h00, attached_sata = 8'h00;
    logic aff_match = 1'b0;
    logic [63:0] conn_addr = 64'h0, aff_addr;
    // Phy control outputs
    logic [7:0] lrst_req, hrst_req, skip_spinup, vrst_req, phy_disabled, errlog_clr, aff_clear, aff_release;
    logic [31:0] min_rate, max_rate, pptv, rsp;
    wire [55:0] pulses = {aff_release, aff_clear, errlog_clr, vrst_req, skip_spinup, hrst_req, lrst_req};
    // Frame fields and expectations
    logic [7:0] f_type = 8'h40, f_func = 8'h91, f_len = 8'h09, virt = 8'h00, exp_dis = 8'h00;
    logic [3:0] f_min = 4'h0, f_max = 4'h0, f_pv = 4'h0;
    logic f_upd = 1'b0, ctl_en = 1'b1, start = 1'b0, stall = 1'b0;
    logic [31:0] exp_min = 32'h0, exp_max = 32'h0, exp_pv = 32'h0;
    logic [319:0] frame = 320'h0;
    logic [55:0] seen = 56'h0;
    int seed = 32'hC14605B2;
    int failures = 0, total_checks = 0;
    phy_control_request_handler u_phy_control_request_handler (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp,
        .hrdata, .rx_valid, .rx_data, .rx_last, .rx_ready, .tx_valid, .tx_data, .tx_last, .tx_ready,
        .conn_phy, .conn_addr, .attached_sata, .aff_phy, .aff_addr, .aff_match, .lrst_req, .hrst_req,
        .skip_spinup, .vrst_req, .phy_disabled, .errlog_clr, .aff_clear, .aff_release, .min_rate,
        .max_rate, .pptv);
    mgmt_initiator_model u_mgmt_initiator_model (.hclk, .hresetn, .start, .stall, .frame, .rx_valid,
        .rx_data, .rx_last, .rx_ready, .tx_valid, .tx_data, .tx_last, .tx_ready, .rsp, .done);
    // Clock, pulses, stalls
    always #4 hclk = ~hclk;
    always @(posedge hclk) seen <= start ? 56'h0 : (seen | pulses);
    always @(posedge hclk) stall <= ($random(seed) & 3) == 0;
    // Verdict and end of run
    task end_of_test;
        $display("Checks %0d, errors %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : end_of_test
    // Compare one value
    task automatic chk(input logic [63:0] got, input logic [63:0] want_v);
        total_checks++;
        if (got !== want_v) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, got, want_v);
        end
    endtask : chk
    // Bounded wait for hready (0) or done (1)
    task automatic waitfor(input bit sel);
        for (int k = 0; k < 600; k++) begin
            @(posedge hclk);
            if ((sel ? done : hready) === 1'b1) return;
        end
        failures++;
        end_of_test();
    endtask : waitfor
    // One single-word bus transfer
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        waitfor(1'b0);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        waitfor(1'b0);
        r = hrdata;
    endtask : ahb
    // Request frame from the current fields
    function automatic logic [319:0] mk(input logic [7:0] ph, input logic [7:0] op);
        logic [319:0] f;
        f = '0;
        f[31:0] = {f_len, 8'h00, f_func, f_type};
        f[87:72] = {op, ph};
        f[95] = f_upd;
        f[263:260] = f_min;
        f[271:268] = f_max;
        f[291:288] = f_pv;
        return f;
    endfunction : mk
    // Expected function result
    function automatic logic [7:0] want(input logic [7:0] ph, input logic [7:0] op);
        logic bad;
        bad = (|f_min && f_min[3:1] != 3'h4) || (|f_max && f_max[3:1] != 3'h4) || (|f_min && |f_max && f_min > f_max);
        if (f_func != 8'h91 || !ctl_en) return 8'h01;
        if ((f_len != 8'h09 && f_len != 8'h00) || ph > 8'h07 || bad || (op >= 8'h01 && op <= 8'h03 &&
            ph == conn_phy) || (op == 8'h06 && !aff_match) || op == 8'h04 || op > 8'h06) return 8'h02;
        return 8'h00;
    endfunction : want
    // One request, all effects
    task automatic go(input logic [7:0] ph, input logic [7:0] op);
        logic [7:0] r, m;
        logic [2:0] p;
        logic a, rs, n;
        logic [55:0] e;
        frame <= mk(ph, op);
        start <= 1'b1;
        @(posedge hclk);
        start <= 1'b0;
        r = want(ph, op);
        p = ph[2:0];
        m = 8'h01 << p;
        a = r == 8'h00;
        rs = a && (op == 8'h01 || op == 8'h02);
        n = rs && !virt[p];
        e = {{8{a && op == 8'h06}} & m, {8{a && op == 8'h02}} & m, {8{a && op == 8'h05}} & m,
            {8{rs && virt[p]}} & m, {8{n && (op == 8'h01 || attached_sata[p])}} & m,
            {8{n && op == 8'h02 && !attached_sata[p]}} & m, {8{n}} & m};
        waitfor(1'b1);
        if (a && op == 8'h03) exp_dis[p] = 1'b1;
        if (rs) exp_dis[p] = 1'b0;
        if (a && f_min != 4'h0) exp_min[4 * p +: 4] = f_min;
        if (a && f_max != 4'h0) exp_max[4 * p +: 4] = f_max;
        if (a && f_upd) exp_pv[4 * p +: 4] = f_pv;
        chk(rsp, {8'h00, r, 8'h91, 8'h41});
        chk(seen, e);
        chk(phy_disabled, exp_dis);
        chk({min_rate, max_rate}, {exp_min, exp_max});
        chk(pptv, exp_pv);
        if (a && op == 8'h06) chk(aff_addr, conn_addr);
    endtask : go
    // Main sequence
    initial begin
        logic [31:0] r;
        logic [79:0] ops;
        logic [71:0] rt;
        int k;
        ops = 80'h03_01_03_02_05_06_06_00_04_07;
        rt = {12'hC97, 12'h00F, 12'h09A, 12'h305, 12'h983, 12'h891};
        hresetn = 1'b0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        chk({hreadyout, hresp, phy_disabled}, 64'h200);
        ahb(1'b0, OFS_CTRL, 32'h0, r);
        chk(r, 32'h1);
        ahb(1'b1, 32'h40, 32'hFFFFFFFF, r);
        ahb(1'b0, 32'h40, 32'h0, r);
        chk(r, 32'h0);
        for (int i = 0; i < 10; i++) begin
            aff_match <= i[0];
            attached_sata <= $random(seed);
            conn_addr <= {$random(seed), $random(seed)};
            go(8'h02, ops[8 * i +: 8]);
        end
        conn_phy <= 8'h02;
        for (int i = 1; i < 6; i++) go(8'h02, i[7:0]);
        conn_phy <= 8'h00;
        f_len = 8'h00;
        go(8'h05, 8'h01);
        f_len = 8'h05;
        go(8'h05, 8'h01);
        f_len = 8'h09;
        f_func = 8'h92;
        go(8'h05, 8'h00);
        f_func = 8'h91;
        go(8'h08, 8'h05);
        for (int i = 0; i < 6; i++) begin
            {f_min, f_max, f_pv} = rt[12 * i +: 12];
            f_upd = i[0];
            go(8'h03, 8'h00);
        end
        {f_min, f_max} = 8'h00;
        ahb(1'b1, OFS_VIRT, 32'h10, r);
        virt = 8'h10;
        go(8'h04, 8'h03);
        go(8'h04, 8'h01);
        go(8'h04, 8'h02);
        ahb(1'b0, OFS_VIRT, 32'h0, r);
        chk(r, 32'h10);
        ahb(1'b1, OFS_VIRT, 32'h0, r);
        virt = 8'h00;
        ahb(1'b1, OFS_CTRL, 32'h0, r);
        ctl_en = 1'b0;
        go(8'h01, 8'h05);
        ahb(1'b1, OFS_CTRL, 32'h1, r);
        ctl_en = 1'b1;
        f_type = 8'h41;
        frame <= mk(8'h01, 8'h05);
        start <= 1'b1;
        @(posedge hclk);
        start <= 1'b0;
        k = 0;
        repeat (80) begin
            @(posedge hclk);
            if (tx_valid !== 1'b0) k++;
        end
        chk({k[7:0], seen}, 64'h0);
        f_type = 8'h40;
        for (int i = 0; i < 60; i++) begin
            conn_phy <= {$random(seed)} % 9;
            attached_sata <= $random(seed);
            aff_match <= $random(seed);
            r = $random(seed);
            f_upd = r[8];
            f_pv = r[15:12];
            f_min = r[1] ? {3'h4, r[0]} : (r[2] ? 4'h0 : r[7:4]);
            f_max = r[17] ? {3'h4, r[16]} : 4'h0;
            go({$random(seed)} % 9, {$random(seed)} % 9);
        end
        end_of_test();
    end
endmodule : phy_control_request_handler_tb
`default_nettype wire
